/* lnmc_checker.sv */
// lnmc_checker.sv: port assertions for lnmc_top, attached by bind
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`include "lnmc_defs.vh"
module lnmc_checker #(
    parameter [`LNMC_CNT_W-1:0] DOM_CYC = 150000
) (
    input wire                  i_clk,
    input wire                  i_rst,
    input wire                  i_battery_supply_ok,
    input wire                  i_regulator_sense_ok,
    input wire                  i_txd,
    input wire                  i_bus,
    input wire                  i_debug_select,
    input wire                  o_bus_dominant,
    input wire                  o_rxd,
    input wire                  o_txd_oe,
    input wire                  o_reset_out_n_oe,
    input wire                  o_ext_regulator_inhibit,
    input wire                  o_regulator_en,
    input wire                  o_watchdog_osc_bias,
    input wire [`LNMC_ST_W-1:0] o_mode
);
    // saturating run length of a low transmit input
    reg [`LNMC_CNT_W-1:0] low_cnt;
    always @(posedge i_clk) begin
        if (i_rst || i_txd)
            low_cnt <= '0;
        else if (low_cnt < DOM_CYC + 8)
            low_cnt <= low_cnt + 1'h1;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_sleep;
        o_mode == `LNMC_ST_SLEEP |-> !o_regulator_en && !o_ext_regulator_inhibit;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep with regulator or inhibit on");
    property p_silent;
        o_mode == `LNMC_ST_SILENT |-> o_regulator_en && !o_ext_regulator_inhibit && !o_bus_dominant;
    endproperty
    a_silent: assert property (p_silent) else $error("silent outputs wrong");
    property p_drive;
        o_bus_dominant |-> !$past(i_txd) || !$past(i_txd, 2) || !$past(i_txd, 3);
    endproperty
    a_drive: assert property (p_drive) else $error("dominant without low transmit");
    property p_batt;
        !i_battery_supply_ok [*4] |-> !o_bus_dominant;
    endproperty
    a_batt: assert property (p_batt) else $error("driving with battery low");
    property p_tout;
        low_cnt > DOM_CYC + 3 |-> !o_bus_dominant;
    endproperty
    a_tout: assert property (p_tout) else $error("dominant past time-out");
    property p_rxd;
        (o_mode == `LNMC_ST_NORMAL && $stable(i_bus)) [*3] |-> o_rxd == i_bus;
    endproperty
    a_rxd: assert property (p_rxd) else $error("receive output not following bus");
    property p_uv;
        $fell(i_regulator_sense_ok) && o_mode == `LNMC_ST_NORMAL
            |-> ##[1:3] o_reset_out_n_oe ##[0:3] o_mode == `LNMC_ST_FAILSAFE;
    endproperty
    a_uv: assert property (p_uv) else $error("undervoltage reset missing");
    property p_txoe;
        o_txd_oe |-> o_mode == `LNMC_ST_FAILSAFE;
    endproperty
    a_txoe: assert property (p_txoe) else $error("transmit pin driven outside fail-safe");
    property p_dbg;
        i_debug_select [*4] |-> !o_watchdog_osc_bias;
    endproperty
    a_dbg: assert property (p_dbg) else $error("watchdog active in debug");
endmodule // lnmc_checker

bind lnmc_top lnmc_checker #(.DOM_CYC(DOM_CYC)) u_checker (
    .i_clk(i_clk), .i_rst(i_rst), .i_battery_supply_ok(i_battery_supply_ok),
    .i_regulator_sense_ok(i_regulator_sense_ok), .i_txd(i_txd), .i_bus(i_bus), .i_debug_select(i_debug_select),
    .o_bus_dominant(o_bus_dominant), .o_rxd(o_rxd), .o_txd_oe(o_txd_oe), .o_reset_out_n_oe(o_reset_out_n_oe),
    .o_ext_regulator_inhibit(o_ext_regulator_inhibit), .o_regulator_en(o_regulator_en),
    .o_watchdog_osc_bias(o_watchdog_osc_bias), .o_mode(o_mode));

/* lnmc_defs.vh */
// lnmc_defs.vh: constants of the single-wire bus node mode controller
// assumes the including file compiles as Verilog-2005 or SystemVerilog
`ifndef LNMC_DEFS_VH
`define LNMC_DEFS_VH

`define LNMC_CLK_MHZ        24'h19
`define LNMC_CYC(us)        ((us) * `LNMC_CLK_MHZ)
`define LNMC_CNT_W          24

// times in microseconds
`define LNMC_DOMINANT_TIMEOUT_US       24'h1770
`define LNMC_T_TXREL_US     24'ha
`define LNMC_T_IGN_DEB_US   24'ha0
`define LNMC_T_RES_US       24'hfa0
`define LNMC_T_BUS_US       24'h64
`define LNMC_T_WAKE_US      24'h32
`define LNMC_T_TRIG_US      24'h5
`define LNMC_T_WD_US        24'h4e20

// one-hot mode codes
`define LNMC_ST_W           5
`define LNMC_ST_UNPWR       5'h01
`define LNMC_ST_FAILSAFE    5'h02
`define LNMC_ST_NORMAL      5'h04
`define LNMC_ST_SILENT      5'h08
`define LNMC_ST_SLEEP       5'h10

// wake-up source codes
`define LNMC_SRC_W          2
`define LNMC_SRC_BUS        2'h0
`define LNMC_SRC_PIN        2'h1
`define LNMC_SRC_IGN        2'h2
`define LNMC_SRC_EN         2'h3

`define LNMC_FIFO_DEPTH     8
`define LNMC_FIFO_AW        3

`endif

/* lnmc_fifo.v */
// lnmc_fifo.v: small flip-flop FIFO with a registered output stage
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
module lnmc_fifo #(
    parameter WIDTH = 2,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             i_clk,
    input  wire             i_rst,
    input  wire             i_in_valid,
    output wire             o_in_ready,
    input  wire [WIDTH-1:0] i_in_data,
    output reg              o_out_valid,
    input  wire             i_out_ready,
    output reg  [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wptr;
    reg [AW-1:0]    rptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;
    wire [AW:0]     depth_w;

    assign depth_w    = DEPTH[AW:0];
    assign o_in_ready = (count != depth_w);
    assign push       = i_in_valid & o_in_ready;
    // output stage refills whenever it is empty or being drained
    assign pop        = (count != {(AW+1){1'b0}}) & (~o_out_valid | i_out_ready);

    always @(posedge i_clk) begin
        if (i_rst) begin
            wptr        <= {AW{1'b0}};
            rptr        <= {AW{1'b0}};
            count       <= {(AW+1){1'b0}};
            o_out_valid <= 1'b0;
            o_out_data  <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                mem[wptr] <= i_in_data;
                wptr      <= wptr + 1'b1;
            end
            if (pop) begin
                o_out_data <= mem[rptr];
                rptr       <= rptr + 1'b1;
            end
            if (pop)
                o_out_valid <= 1'b1;
            else if (i_out_ready)
                o_out_valid <= 1'b0;
            if (push & ~pop)
                count <= count + 1'b1;
            else if (pop & ~push)
                count <= count - 1'b1;
        end
    end
endmodule // lnmc_fifo

/* lnmc_host.sv */
// lnmc_host.sv: host model, watchdog trigger and wake-source reader
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
module lnmc_host #(
    parameter PERIOD = 100,
    parameter LOW    = 6
) (
    input  wire i_clk,
    input  wire i_rst,
    input  wire i_trig_en,
    input  wire i_slow,
    output reg  o_watchdog_trigger_n,
    output reg  o_wake_ready
);
    reg [7:0] cnt;
    always @(posedge i_clk) begin
        if (i_rst || cnt == PERIOD - 1)
            cnt <= 8'h00;
        else
            cnt <= cnt + 8'h01;
        // low longer than the minimum, period well inside the watchdog time
        o_watchdog_trigger_n <= !(i_trig_en && !i_rst && cnt < LOW);
        o_wake_ready <= !i_slow || cnt[1:0] == 2'h3;
    end
endmodule // lnmc_host

/* lnmc_top.v */
// lnmc_top.v: mode control, transmit/receive paths, wake-up and reset logic
// of a single-wire bus node system-basis chip.
// assumes all pin inputs are already synchronous to i_clk; analog monitors
// arrive as clean levels; i_clk runs at 25 MHz.
`timescale 1ns/1ps
`include "lnmc_defs.vh"
module lnmc_top #(
    parameter [`LNMC_CNT_W-1:0] DOM_CYC   = `LNMC_CYC(`LNMC_DOMINANT_TIMEOUT_US),
    parameter [`LNMC_CNT_W-1:0] REL_CYC   = `LNMC_CYC(`LNMC_T_TXREL_US),
    parameter [`LNMC_CNT_W-1:0] IGN_CYC   = `LNMC_CYC(`LNMC_T_IGN_DEB_US),
    parameter [`LNMC_CNT_W-1:0] RES_CYC   = `LNMC_CYC(`LNMC_T_RES_US),
    parameter [`LNMC_CNT_W-1:0] BUS_CYC   = `LNMC_CYC(`LNMC_T_BUS_US),
    parameter [`LNMC_CNT_W-1:0] WAKE_CYC  = `LNMC_CYC(`LNMC_T_WAKE_US),
    parameter [`LNMC_CNT_W-1:0] TRIG_CYC  = `LNMC_CYC(`LNMC_T_TRIG_US),
    parameter [`LNMC_CNT_W-1:0] WD_CYC    = `LNMC_CYC(`LNMC_T_WD_US)
) (
    input  wire                  i_clk,
    input  wire                  i_rst,
    input  wire                  i_battery_supply_ok,
    input  wire                  i_regulator_sense_ok,
    input  wire                  i_mode_enable,
    input  wire                  i_txd,
    input  wire                  i_bus,
    input  wire                  i_wake_n,
    input  wire                  i_ignition_wake_in,
    input  wire                  i_debug_select,
    input  wire                  i_watchdog_trigger_n,
    input  wire                  i_wake_ready,
    output reg                   o_bus_dominant,
    output reg                   o_rxd,
    output reg                   o_rxd_oe,
    output reg                   o_txd,
    output reg                   o_txd_oe,
    output reg                   o_reset_out_n,
    output reg                   o_reset_out_n_oe,
    output reg                   o_ext_regulator_inhibit,
    output reg                   o_regulator_en,
    output reg                   o_regulator_full,
    output reg                   o_watchdog_osc_bias,
    output reg  [`LNMC_ST_W-1:0] o_mode,
    output wire                  o_wake_valid,
    output wire [`LNMC_SRC_W-1:0] o_wake_src
);
    localparam [`LNMC_CNT_W-1:0] CNT_ZERO = {`LNMC_CNT_W{1'b0}};
    localparam [`LNMC_CNT_W-1:0] CNT_ONE  = {{(`LNMC_CNT_W-1){1'b0}}, 1'b1};

    reg  [`LNMC_ST_W-1:0]  state;
    reg  [`LNMC_ST_W-1:0]  next_state;
    reg  [`LNMC_CNT_W-1:0] dom_cnt;
    reg  [`LNMC_CNT_W-1:0] rel_cnt;
    reg  [`LNMC_CNT_W-1:0] ign_cnt;
    reg  [`LNMC_CNT_W-1:0] wake_cnt;
    reg  [`LNMC_CNT_W-1:0] bus_cnt;
    reg  [`LNMC_CNT_W-1:0] trig_cnt;
    reg  [`LNMC_CNT_W-1:0] wd_cnt;
    reg  [`LNMC_CNT_W-1:0] res_cnt;
    reg                    dom_timeout;
    reg                    en_prev;
    reg                    ign_prev;
    reg                    ign_arm;
    reg                    wake_prev_n;
    reg                    wake_arm;
    reg                    bus_prev;
    reg                    uv_reset;
    reg                    wake_pend;
    reg [`LNMC_SRC_W-1:0]  wake_pend_src;
    reg                    last_local;
    reg                    wake_shown;

    wire st_unpwr    = state[0];
    wire st_failsafe = state[1];
    wire st_normal   = state[2];
    wire st_silent   = state[3];
    wire st_sleep    = state[4];
    wire asleep      = st_silent | st_sleep;

    // saturating increment keeps idle timers from wrapping into a false expiry
    function [`LNMC_CNT_W-1:0] sat_inc;
        input [`LNMC_CNT_W-1:0] c;
        begin
            sat_inc = (&c) ? c : c + CNT_ONE;
        end
    endfunction

    // regulator is off on purpose in Sleep, so its sense is ignored there
    wire reg_uv     = ~i_regulator_sense_ok & ~st_sleep & ~st_unpwr;
    wire trig_event = ~i_watchdog_trigger_n & (trig_cnt == TRIG_CYC - CNT_ONE);
    wire wd_active  = (st_normal | st_failsafe) & ~i_debug_select;
    wire wd_fail    = wd_active & (wd_cnt >= WD_CYC);
    wire res_active = reg_uv | (res_cnt != CNT_ZERO);
    wire en_fall    = en_prev & ~i_mode_enable;

    wire ign_fire  = ign_arm & i_ignition_wake_in & (ign_cnt >= IGN_CYC);
    wire pin_fire  = wake_arm & ~i_wake_n & (wake_cnt >= WAKE_CYC);
    wire bus_fire  = i_bus & ~bus_prev & (bus_cnt >= BUS_CYC);
    wire en_fire   = i_mode_enable;

    wire fifo_in_ready;
    wire wake_take = wake_pend & fifo_in_ready;

    lnmc_fifo #(
        .WIDTH (`LNMC_SRC_W),
        .DEPTH (`LNMC_FIFO_DEPTH),
        .AW    (`LNMC_FIFO_AW)
    ) u_wake_fifo (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_in_valid  (wake_pend),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (wake_pend_src),
        .o_out_valid (o_wake_valid),
        .i_out_ready (i_wake_ready),
        .o_out_data  (o_wake_src)
    );

    // mode selection; a wake-up only takes effect once its source is logged
    always @* begin
        next_state = state;
        case (state)
            `LNMC_ST_UNPWR: begin
                if (i_battery_supply_ok)
                    next_state = `LNMC_ST_FAILSAFE;
            end
            `LNMC_ST_FAILSAFE: begin
                if (~res_active & i_mode_enable)
                    next_state = `LNMC_ST_NORMAL;
            end
            `LNMC_ST_NORMAL: begin
                if (res_active)
                    next_state = `LNMC_ST_FAILSAFE;
                else if (en_fall & i_txd)
                    next_state = `LNMC_ST_SILENT;
                else if (en_fall)
                    next_state = `LNMC_ST_SLEEP;
            end
            `LNMC_ST_SILENT, `LNMC_ST_SLEEP: begin
                if (res_active | ~i_battery_supply_ok)
                    next_state = `LNMC_ST_FAILSAFE;
                else if (wake_take & (wake_pend_src == `LNMC_SRC_EN))
                    next_state = `LNMC_ST_NORMAL;
                else if (wake_take)
                    next_state = `LNMC_ST_FAILSAFE;
            end
            default: next_state = `LNMC_ST_FAILSAFE;
        endcase
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            state <= `LNMC_ST_UNPWR;
        end else begin
            state <= next_state;
        end
    end

    // edge history and input timers
    always @(posedge i_clk) begin
        if (i_rst) begin
            en_prev     <= 1'b0;
            ign_prev    <= 1'b0;
            ign_arm     <= 1'b0;
            ign_cnt     <= CNT_ZERO;
            wake_prev_n <= 1'b1;
            wake_arm    <= 1'b0;
            wake_cnt    <= CNT_ZERO;
            bus_prev    <= 1'b1;
            bus_cnt     <= CNT_ZERO;
            trig_cnt    <= CNT_ZERO;
        end else begin
            en_prev     <= i_mode_enable;
            ign_prev    <= i_ignition_wake_in;
            wake_prev_n <= i_wake_n;
            bus_prev    <= i_bus;
            // a steady high level never re-arms, so a held ignition allows sleep
            if (i_ignition_wake_in & ~ign_prev)
                ign_arm <= 1'b1;
            else if (~i_ignition_wake_in | ign_fire)
                ign_arm <= 1'b0;
            ign_cnt <= (ign_arm & i_ignition_wake_in) ? sat_inc(ign_cnt) : CNT_ZERO;
            if (~i_wake_n & wake_prev_n)
                wake_arm <= 1'b1;
            else if (i_wake_n | pin_fire)
                wake_arm <= 1'b0;
            wake_cnt <= (wake_arm & ~i_wake_n) ? sat_inc(wake_cnt) : CNT_ZERO;
            bus_cnt  <= ~i_bus ? sat_inc(bus_cnt) : (bus_prev ? CNT_ZERO : bus_cnt);
            trig_cnt <= ~i_watchdog_trigger_n ? sat_inc(trig_cnt) : CNT_ZERO;
        end
    end

    // transmit dominant time-out
    always @(posedge i_clk) begin
        if (i_rst) begin
            dom_cnt     <= CNT_ZERO;
            rel_cnt     <= CNT_ZERO;
            dom_timeout <= 1'b0;
        end else begin
            dom_cnt <= (st_normal & ~i_txd) ? sat_inc(dom_cnt) : CNT_ZERO;
            rel_cnt <= (dom_timeout & i_txd) ? sat_inc(rel_cnt) : CNT_ZERO;
            if (dom_cnt >= DOM_CYC)
                dom_timeout <= 1'b1;
            else if (rel_cnt >= REL_CYC)
                dom_timeout <= 1'b0;
        end
    end

    // watchdog and reset timing
    always @(posedge i_clk) begin
        if (i_rst) begin
            wd_cnt   <= CNT_ZERO;
            res_cnt  <= CNT_ZERO;
            uv_reset <= 1'b0;
        end else begin
            if (~wd_active | trig_event | res_active)
                wd_cnt <= CNT_ZERO;
            else
                wd_cnt <= sat_inc(wd_cnt);
            if (st_unpwr & i_battery_supply_ok)
                res_cnt <= RES_CYC;
            else if (reg_uv | wd_fail)
                res_cnt <= RES_CYC;
            else if (res_cnt != CNT_ZERO)
                res_cnt <= res_cnt - CNT_ONE;
            if (reg_uv)
                uv_reset <= 1'b1;
            else if (res_cnt == CNT_ZERO)
                uv_reset <= 1'b0;
        end
    end

    // wake-up capture; a new request is only taken while none is pending, so the clear of the one being logged wins
    always @(posedge i_clk) begin
        if (i_rst) begin
            wake_pend     <= 1'b0;
            wake_pend_src <= `LNMC_SRC_BUS;
            last_local    <= 1'b0;
            wake_shown    <= 1'b0;
        end else begin
            if (asleep & ~wake_pend & en_fire) begin
                wake_pend     <= 1'b1;
                wake_pend_src <= `LNMC_SRC_EN;
            end else if (asleep & ~wake_pend & pin_fire) begin
                wake_pend     <= 1'b1;
                wake_pend_src <= `LNMC_SRC_PIN;
            end else if (asleep & ~wake_pend & ign_fire) begin
                wake_pend     <= 1'b1;
                wake_pend_src <= `LNMC_SRC_IGN;
            end else if (asleep & ~wake_pend & bus_fire) begin
                wake_pend     <= 1'b1;
                wake_pend_src <= `LNMC_SRC_BUS;
            end else if (wake_take | ~asleep) begin
                wake_pend <= 1'b0;
            end
            if (wake_take)
                last_local <= (wake_pend_src == `LNMC_SRC_PIN) | (wake_pend_src == `LNMC_SRC_IGN);
            if (wake_take & (wake_pend_src != `LNMC_SRC_EN))
                wake_shown <= 1'b1;
            else if (st_normal)
                wake_shown <= 1'b0;
        end
    end

    // pin outputs follow the present mode one cycle later
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_bus_dominant          <= 1'b0;
            o_rxd                   <= 1'b0;
            o_rxd_oe                <= 1'b0;
            o_txd                   <= 1'b1;
            o_txd_oe                <= 1'b0;
            o_reset_out_n           <= 1'b0;
            o_reset_out_n_oe        <= 1'b0;
            o_ext_regulator_inhibit <= 1'b0;
            o_regulator_en          <= 1'b0;
            o_regulator_full        <= 1'b0;
            o_watchdog_osc_bias     <= 1'b0;
            o_mode                  <= `LNMC_ST_UNPWR;
        end else begin
            o_mode         <= state;
            // on leaving fail-safe the pin still reads back our own latched low for a cycle
            o_bus_dominant <= st_normal & ~o_txd_oe & ~i_txd & ~dom_timeout & i_battery_supply_ok;
            o_rxd_oe       <= ~st_unpwr;
            if (st_normal)
                o_rxd <= i_bus;
            else if (st_failsafe)
                o_rxd <= ~wake_shown;
            else
                o_rxd <= st_silent;
            o_txd_oe      <= st_failsafe;
            o_txd         <= ~(st_failsafe & last_local);
            o_reset_out_n <= 1'b0;
            // sleep keeps reset low because the regulator is off
            o_reset_out_n_oe        <= res_active | st_sleep;
            o_ext_regulator_inhibit <= (st_normal | st_failsafe) & ~uv_reset & ~reg_uv;
            o_regulator_en          <= ~st_unpwr & ~st_sleep;
            o_regulator_full        <= st_normal | st_failsafe | st_silent;
            o_watchdog_osc_bias     <= wd_active;
        end
    end
endmodule // lnmc_top

/* lnmc_top_tb.sv */
// lnmc_top_tb.sv: self-checking bench of the mode controller
// assumes lnmc_top, lnmc_host and lnmc_checker are compiled with it
`timescale 1ns/1ps
`include "lnmc_defs.vh"
module lnmc_top_tb;
    localparam DOM = 200, REL = 250, IGN = 40, RES = 50, BUS = 20, WAKE = 10, WD = 400;
    reg        clk = 1'h0;
    reg        rst = 1'h1;
    reg        bat = 1'h1;
    reg        sense = 1'h1;
    reg        en = 1'h0;
    reg        txd = 1'h1;
    reg        bus_ext = 1'h1;
    reg        wake_n = 1'h1;
    reg        ign = 1'h0;
    reg        dbg = 1'h0;
    reg        trig_en = 1'h1;
    reg        slow = 1'h0;
    reg  [1:0] last_src = 2'h0;
    integer    fail_count = 0;
    integer    checked = 0;
    integer    pops = 0;
    integer    base = 0;
    wire       rxd_oe, reg_full, rst_n;
    wire       trig_n, ready, dom, rxd, txd_o, txd_oe, rst_oe, inhibit, reg_en, bias, valid;
    wire [4:0] mode;
    wire [1:0] src;
    lnmc_top #(.DOM_CYC(DOM), .REL_CYC(REL), .RES_CYC(RES), .WD_CYC(WD), .IGN_CYC(IGN), .BUS_CYC(BUS),
               .WAKE_CYC(WAKE), .TRIG_CYC(4)) u_dut (
        .i_clk(clk), .i_rst(rst), .i_battery_supply_ok(bat), .i_regulator_sense_ok(sense),
        .i_mode_enable(en), .i_txd((txd_oe === 1'h1) ? txd_o : txd), .i_bus((dom === 1'h1) ? 1'h0 : bus_ext),
        .i_wake_n(wake_n), .i_ignition_wake_in(ign), .i_debug_select(dbg), .i_watchdog_trigger_n(trig_n),
        .i_wake_ready(ready), .o_bus_dominant(dom), .o_rxd(rxd), .o_rxd_oe(rxd_oe), .o_txd(txd_o), .o_txd_oe(txd_oe),
        .o_reset_out_n(rst_n), .o_reset_out_n_oe(rst_oe), .o_ext_regulator_inhibit(inhibit), .o_regulator_en(reg_en),
        .o_regulator_full(reg_full), .o_watchdog_osc_bias(bias), .o_mode(mode), .o_wake_valid(valid),
        .o_wake_src(src));
    lnmc_host u_host (.i_clk(clk), .i_rst(rst), .i_trig_en(trig_en), .i_slow(slow),
        .o_watchdog_trigger_n(trig_n), .o_wake_ready(ready));
    always #20 clk = ~clk;
    always @(posedge clk)
        if (valid === 1'h1 && ready === 1'h1) begin
            last_src <= src;
            pops     <= pops + 1;
        end
    task give_verdict;
        begin
            $display("comparisons %0d mismatches %0d", checked, fail_count);
            if (fail_count == 0 && checked > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task chk(input [8*8-1:0] what, input [7:0] exp, input [7:0] got);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("MISMATCH %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge clk);
    endtask
    // sel 0 waits on the mode, sel 1 on the reset pull-down
    task wt(input sel, input [4:0] exp, input integer bound);
        integer k;
        begin
            k = 0;
            while ((sel ? {4'h0, rst_oe} : mode) !== exp && k < bound) begin
                @(negedge clk);
                k = k + 1;
            end
            chk(sel ? "resetoe" : "mode", exp, sel ? {4'h0, rst_oe} : mode);
            if (k >= bound)
                give_verdict;
        end
    endtask
    task t_power;
        integer n, k;
        begin
            n = 0;
            for (k = 0; k < RES + 30 && mode !== `LNMC_ST_NORMAL; k = k + 1) begin
                if (k == 1)
                    chk("rxdoe", 0, rxd_oe);
                if (k == 2)
                    en = 1'h1;
                if (k == 12) begin
                    chk("fsafe", `LNMC_ST_FAILSAFE, mode);
                    chk("regen", 1, reg_en);
                    chk("txdoe", 1, txd_oe);
                    chk("rxdoe", 1, rxd_oe);
                end
                n = n + (rst_oe === 1'h1);
                @(negedge clk);
            end
            chk("reslen", RES, n);
            chk("mode", `LNMC_ST_NORMAL, mode);
            if (k >= RES + 30)
                give_verdict;
        end
    endtask
    task t_path;
        begin
            txd = 1'h0;
            cyc(6);
            chk("busdom", 1, dom);
            chk("rxd", 0, rxd);
            chk("bias", 1, bias);
            chk("regfull", 1, reg_full);
            bat = 1'h0;
            cyc(6);
            chk("busdom", 0, dom);
            bat = 1'h1;
            txd = 1'h1;
            cyc(6);
            chk("rxd", 1, rxd);
        end
    endtask
    task dominant_timeout;
        begin
            txd = 1'h0;
            cyc(DOM + 8);
            chk("busdom", 0, dom);
            txd = 1'h1;
            cyc(REL / 2);
            txd = 1'h0;
            cyc(6);
            chk("busdom", 0, dom);
            txd = 1'h1;
            cyc(REL + 8);
            txd = 1'h0;
            cyc(6);
            chk("busdom", 1, dom);
            txd = 1'h1;
            cyc(6);
        end
    endtask
    task t_silent;
        begin
            slow = 1'h1;
            en = 1'h0;
            wt(0, `LNMC_ST_SILENT, 6);
            chk("inhibit", 0, inhibit);
            chk("regfull", 1, reg_full);
            base = pops;
            bus_ext = 1'h0;
            cyc(BUS + 5);
            bus_ext = 1'h1;
            wt(0, `LNMC_ST_FAILSAFE, 8);
            cyc(6);
            chk("rxd", 0, rxd);
            chk("inhibit", 1, inhibit);
            chk("src", `LNMC_SRC_BUS, last_src);
            chk("pops", base + 1, pops);
            slow = 1'h0;
            en = 1'h1;
            wt(0, `LNMC_ST_NORMAL, 8);
        end
    endtask
    task t_sleep;
        begin
            txd = 1'h0;
            en = 1'h0;
            wt(0, `LNMC_ST_SLEEP, 6);
            chk("regen", 0, reg_en);
            chk("regfull", 0, reg_full);
            txd = 1'h1;
            base = pops;
            wake_n = 1'h0;
            cyc(WAKE + 5);
            wake_n = 1'h1;
            wt(0, `LNMC_ST_FAILSAFE, 8);
            cyc(6);
            chk("txd", 0, txd_o);
            chk("src", `LNMC_SRC_PIN, last_src);
            chk("pops", base + 1, pops);
            en = 1'h1;
            wt(0, `LNMC_ST_NORMAL, RES + 30);
        end
    endtask
    task t_ign;
        begin
            ign = 1'h1;
            en = 1'h0;
            wt(0, `LNMC_ST_SILENT, 6);
            ign = 1'h0;
            cyc(5);
            ign = 1'h1;
            cyc(IGN / 2);
            ign = 1'h0;
            cyc(IGN);
            chk("mode", `LNMC_ST_SILENT, mode);
            base = pops;
            ign = 1'h1;
            wt(0, `LNMC_ST_FAILSAFE, IGN + 8);
            cyc(6);
            chk("txd", 0, txd_o);
            chk("src", `LNMC_SRC_IGN, last_src);
            chk("pops", base + 1, pops);
            ign = 1'h0;
            en = 1'h1;
            wt(0, `LNMC_ST_NORMAL, RES + 30);
        end
    endtask
    task t_en;
        begin
            en = 1'h0;
            wt(0, `LNMC_ST_SILENT, 6);
            base = pops;
            en = 1'h1;
            wt(0, `LNMC_ST_NORMAL, 8);
            cyc(6);
            chk("src", `LNMC_SRC_EN, last_src);
            chk("pops", base + 1, pops);
        end
    endtask
    task t_uv;
        begin
            sense = 1'h0;
            wt(0, `LNMC_ST_FAILSAFE, 8);
            chk("resetoe", 1, rst_oe);
            chk("inhibit", 0, inhibit);
            chk("resetn", 0, rst_n);
            sense = 1'h1;
            wt(1, 0, RES + 30);
            wt(0, `LNMC_ST_NORMAL, 8);
        end
    endtask
    task t_wd;
        begin
            dbg = 1'h1;
            trig_en = 1'h0;
            cyc(WD + 50);
            chk("resetoe", 0, rst_oe);
            chk("bias", 0, bias);
            dbg = 1'h0;
            wt(1, 1, WD + 30);
            wt(0, `LNMC_ST_FAILSAFE, 6);
            trig_en = 1'h1;
            wt(1, 0, RES + 30);
            wt(0, `LNMC_ST_NORMAL, 8);
        end
    endtask
    initial begin
        cyc(8);
        rst = 1'h0;
        t_power;
        t_path;
        dominant_timeout;
        t_silent;
        t_sleep;
        t_ign;
        t_en;
        t_uv;
        t_wd;
        give_verdict;
    end
endmodule // lnmc_top_tb
